// ---- rtl/mcacsr_pkg.sv ----
package mcacsr_pkg;
	// register indices
	localparam logic [4:0] ADDR_CONDITION = 5'h00;
	localparam logic [4:0] ADDR_SETUP     = 5'h01;
	localparam logic [4:0] ADDR_REVISION  = 5'h02;
	localparam logic [4:0] ADDR_NVM_WORD  = 5'h03;
	localparam logic [4:0] ADDR_NVM_GATE  = 5'h04;
	localparam logic [4:0] ADDR_PULSE_LEN = 5'h05;
	localparam logic [4:0] ADDR_RESTART   = 5'h14;
	// setup word fields
	localparam int BIT_LEVEL     = 15;
	localparam int BIT_SRC_LO    = 13;
	localparam int BIT_RAMP      = 12;
	localparam int BIT_DACTEST   = 11;
	localparam int BIT_RESERVED  = 10;
	localparam int BIT_SELFGATE  = 9;
	localparam int BIT_PILEUP    = 8;
	localparam int BIT_SELFTRIG  = 7;
	localparam int BIT_STORE     = 6;
	localparam int BIT_FULLCLR   = 5;
	localparam int BIT_SLIDE     = 4;
	localparam int BIT_RATE_LO   = 1;
	localparam int BIT_COUNT_EN  = 0;
	// condition word fields
	localparam int BIT_NVM_BUSY  = 3;
	localparam int BIT_FULL      = 2;
	localparam int BIT_EMPTY     = 1;
	localparam int BIT_HISPEED   = 0;
	// reset values
	localparam logic [15:0] SETUP_RESET     = 16'h000e;
	localparam logic [15:0] NVM_WORD_RESET  = 16'h0000;
	localparam logic [15:0] PULSE_LEN_RESET = 16'h0000;
	// revision (values arbitrary)
	localparam logic [7:0] REV_MAJOR = 8'h01;
	localparam logic [7:0] REV_MINOR = 8'h00;
	// timing
	localparam int CLK_HZ         = 50_000_000;
	localparam int PULSE_UNIT_NS  = 1600;
	localparam int PULSE_UNIT_CYC = (PULSE_UNIT_NS * (CLK_HZ / 1_000_000)) / 1000;
	// self trigger rates in samples per second for each rate code
	localparam int RATE_SPS [8] = '{600, 70_000, 140_000, 250_000, 420_000, 635_000,
		850_000, 1_000_000};
	// output source codes
	typedef enum logic [1:0] {
		SRC_FULL  = 2'b00,
		SRC_PEAK  = 2'b01,
		SRC_LEVEL = 2'b10,
		SRC_PULSE = 2'b11
	} mcacsr_src_type;
	typedef enum logic [1:0] {
		PS_IDLE = 2'b01,
		PS_RUN  = 2'b10
	} mcacsr_pulse_type;
endpackage : mcacsr_pkg

// ---- rtl/mcacsr_divider.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// period divider giving a one-cycle enable
// ****************************************
module mcacsr_divider
	import mcacsr_pkg::*;
#(
	parameter int W = 17
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         run,
	input  wire logic [W-1:0] period,
	output logic              tick
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic         next_tick;

	// counts period cycles, stopped counter holds zero
	always_comb begin
		next_count = count;
		next_tick  = 1'b0;
		if (!run) begin
			next_count = '0;
		end else if (count >= period - W'(1)) begin
			next_count = '0;
			next_tick  = 1'b1;
		end else begin
			next_count = count + W'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end
endmodule : mcacsr_divider
`default_nettype wire

// ---- rtl/mcacsr_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - status bit3 shows flash busy
// - status bit2 sticky full until cleared
// - status bit1 shows buffer empty
// - status bit0 shows high speed link
// - bit15 is programmed output level
// - bits14:13 pick front output source
// - bit12 picks ramp or random scale
// - bit11 DAC test mode, sliding off
// - bit9 picks self gate or external
// - bit8 enables pile-up input sensing
// - bit6 gates storage into buffer
// - bit5 forces full flag clear
// - bit4 enables sliding scale
// - bits3:1 pick internal request rate
// - bit0 enables scaler and timers
// - revision: major high, minor low
// - flash word port, one word per access
// - flash gate bit0 permits flash access
// - pulser write starts value times 1.6us
// - restart write resets setup word, clears full flag
module mcacsr_regs
	import mcacsr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	input  wire logic        nvmBusy,
	input  wire logic        bufferFilled,
	input  wire logic        bufferEmpty,
	input  wire logic        linkHighSpeed,
	input  wire logic        peakDetect,
	input  wire logic [15:0] nvmReadWord,
	output logic             front_panel_output,
	output logic             rampMode,
	output logic             dacTestMode,
	output logic             slideOn,
	output logic             selfGate,
	output logic             pileup_sense_on,
	output logic             storeOn,
	output logic             countOn,
	output logic             selfConvReq,
	output logic             softRestart,
	output logic             nvm_access_permit,
	output logic      [15:0] nvm_word,
	output logic             nvmWrStrobe,
	output logic             nvmRdStrobe
);
	// ****************************************
	// register state
	// ****************************************
	logic [15:0] setup;
	logic [15:0] next_setup;
	logic [15:0] pulseLen;
	logic [15:0] next_pulseLen;
	logic [15:0] next_nvm_word;
	logic        next_permit;
	logic        fullFlag;
	logic        next_fullFlag;
	logic [15:0] next_regRdata;
	logic        next_restart;
	logic        next_nvmWr;
	logic        next_nvmRd;
	logic        wrSetup;
	logic        wrRestart;

	assign wrSetup   = regWr && (regAddr == ADDR_SETUP);
	assign wrRestart = regWr && (regAddr == ADDR_RESTART);

	// register writes; restart returns the setup word to reset
	always_comb begin
		next_setup    = setup;
		next_pulseLen = pulseLen;
		next_nvm_word = nvm_word;
		next_permit   = nvm_access_permit;
		if (wrRestart) begin
			next_setup = SETUP_RESET;
		end else if (wrSetup) begin
			next_setup               = regWdata;
			next_setup[BIT_RESERVED] = 1'b0;
		end
		if (regWr && regAddr == ADDR_PULSE_LEN) begin
			next_pulseLen = regWdata;
		end
		if (regWr && regAddr == ADDR_NVM_WORD) begin
			next_nvm_word = regWdata;
		end else if (nvmRdStrobe) begin
			next_nvm_word = nvmReadWord; // fetched word lands a cycle after the read
		end
		if (regWr && regAddr == ADDR_NVM_GATE) begin
			next_permit = regWdata[0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			setup             <= SETUP_RESET;
			pulseLen          <= PULSE_LEN_RESET;
			nvm_word          <= NVM_WORD_RESET;
			nvm_access_permit <= 1'b0;
		end else begin
			setup             <= next_setup;
			pulseLen          <= next_pulseLen;
			nvm_word          <= next_nvm_word;
			nvm_access_permit <= next_permit;
		end
	end

	// ****************************************
	// sticky full flag
	// ****************************************
	// the clear bit holds the flag low while set; set wins only when clear is off
	always_comb begin
		next_fullFlag = fullFlag;
		if (wrRestart || setup[BIT_FULLCLR]) begin
			next_fullFlag = 1'b0;
		end else if (bufferFilled) begin
			next_fullFlag = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fullFlag <= 1'b0;
		end else begin
			fullFlag <= next_fullFlag;
		end
	end

	// ****************************************
	// read port and strobes
	// ****************************************
	// unmapped index reads zero
	always_comb begin
		next_regRdata = 16'h0000;
		if (regRd) begin
			case (regAddr)
				ADDR_CONDITION: begin
					next_regRdata[BIT_NVM_BUSY] = nvmBusy;
					next_regRdata[BIT_FULL]     = fullFlag;
					next_regRdata[BIT_EMPTY]    = bufferEmpty;
					next_regRdata[BIT_HISPEED]  = linkHighSpeed;
				end
				ADDR_SETUP:     next_regRdata = setup;
				ADDR_REVISION:  next_regRdata = {REV_MAJOR, REV_MINOR};
				ADDR_NVM_WORD:  next_regRdata = nvm_word;
				ADDR_NVM_GATE:  next_regRdata = {15'h0000, nvm_access_permit};
				ADDR_PULSE_LEN: next_regRdata = pulseLen;
				default:        next_regRdata = 16'h0000;
			endcase
		end
		next_restart = wrRestart;
		// flash transfers only pass while permitted
		next_nvmWr = regWr && regAddr == ADDR_NVM_WORD && nvm_access_permit;
		next_nvmRd = regRd && regAddr == ADDR_NVM_WORD && nvm_access_permit;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			regRdata    <= 16'h0000;
			softRestart <= 1'b0;
			nvmWrStrobe <= 1'b0;
			nvmRdStrobe <= 1'b0;
		end else begin
			regRdata    <= next_regRdata;
			softRestart <= next_restart;
			nvmWrStrobe <= next_nvmWr;
			nvmRdStrobe <= next_nvmRd;
		end
	end

	// ****************************************
	// pulser: value times 1.6 us
	// ****************************************
	mcacsr_pulse_type pState;
	mcacsr_pulse_type next_pState;
	logic [15:0]      units;
	logic [15:0]      next_units;
	logic [6:0]       unitCnt;
	logic [6:0]       next_unitCnt;
	logic             pulseOn;

	// a new write restarts the pulse; zero length gives no pulse
	always_comb begin
		next_pState  = pState;
		next_units   = units;
		next_unitCnt = unitCnt;
		if (regWr && regAddr == ADDR_PULSE_LEN) begin
			next_units   = regWdata;
			next_unitCnt = '0;
			next_pState  = (regWdata == 16'h0000) ? PS_IDLE : PS_RUN;
		end else begin
			case (pState)
				PS_IDLE: next_pState = PS_IDLE;
				PS_RUN: begin
					if (unitCnt == 7'(PULSE_UNIT_CYC - 1)) begin
						next_unitCnt = '0;
						next_units   = units - 16'h0001;
						if (units == 16'h0001) begin
							next_pState = PS_IDLE;
						end
					end else begin
						next_unitCnt = unitCnt + 7'h01;
					end
				end
				default: next_pState = PS_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pState  <= PS_IDLE;
			units   <= 16'h0000;
			unitCnt <= 7'h00;
		end else begin
			pState  <= next_pState;
			units   <= next_units;
			unitCnt <= next_unitCnt;
		end
	end

	assign pulseOn = (pState == PS_RUN);

	// ****************************************
	// self trigger rate and outputs
	// ****************************************
	logic [16:0] ratePeriod;
	logic        rateTick;

	// period in cycles from the rate code; fine enough for a test feature
	always_comb begin
		ratePeriod = 17'(CLK_HZ / RATE_SPS[setup[BIT_RATE_LO +: 3]]);
	end

	mcacsr_divider #(
		.W (17)
	) u_rate (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.run    (setup[BIT_SELFTRIG]),
		.period (ratePeriod),
		.tick   (rateTick)
	);

	logic next_front;

	// front output source selection
	always_comb begin
		case (mcacsr_src_type'(setup[BIT_SRC_LO +: 2]))
			SRC_FULL:  next_front = fullFlag;
			SRC_PEAK:  next_front = peakDetect;
			SRC_LEVEL: next_front = setup[BIT_LEVEL];
			SRC_PULSE: next_front = pulseOn;
			default:   next_front = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			front_panel_output <= 1'b0;
			rampMode           <= 1'b0;
			dacTestMode        <= 1'b0;
			slideOn            <= 1'b0;
			selfGate           <= 1'b0;
			pileup_sense_on    <= 1'b0;
			storeOn            <= 1'b0;
			countOn            <= 1'b0;
			selfConvReq        <= 1'b0;
		end else begin
			front_panel_output <= next_front;
			rampMode           <= next_setup[BIT_RAMP];
			dacTestMode        <= next_setup[BIT_DACTEST];
			slideOn            <= next_setup[BIT_SLIDE] && !next_setup[BIT_DACTEST];
			selfGate           <= next_setup[BIT_SELFGATE];
			pileup_sense_on    <= next_setup[BIT_PILEUP];
			storeOn            <= next_setup[BIT_STORE];
			countOn            <= next_setup[BIT_COUNT_EN];
			selfConvReq        <= rateTick && setup[BIT_SELFTRIG];
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	AST_BUSY_READ: assert property (regRd && regAddr == ADDR_CONDITION |=>
		regRdata[BIT_NVM_BUSY] == $past(nvmBusy)) else $error("busy bit wrong");
	AST_FULL_STICKY: assert property (fullFlag && !setup[BIT_FULLCLR] && !wrRestart |=>
		fullFlag) else $error("full flag dropped");
	AST_EMPTY_READ: assert property (regRd && regAddr == ADDR_CONDITION |=>
		regRdata[BIT_EMPTY] == $past(bufferEmpty)) else $error("empty bit wrong");
	AST_LEVEL_OUT: assert property (setup[14:13] == 2'b10 |=>
		front_panel_output == $past(setup[BIT_LEVEL])) else $error("level output wrong");
	AST_FULL_OUT: assert property (setup[14:13] == 2'b00 |=>
		front_panel_output == $past(fullFlag)) else $error("full output wrong");
	AST_NO_SELF: assert property (!setup[BIT_SELFTRIG] |=> !selfConvReq)
		else $error("internal request while off");
	AST_CLR_FLAG: assert property (setup[BIT_FULLCLR] |=> !fullFlag)
		else $error("full flag not cleared");
	AST_RESERVED: assert property (!setup[BIT_RESERVED])
		else $error("reserved bit set");
	AST_REV: assert property (regRd && regAddr == ADDR_REVISION |=>
		regRdata == {REV_MAJOR, REV_MINOR}) else $error("revision wrong");
	AST_PULSE_LEN: assert property (regWr && regAddr == ADDR_PULSE_LEN &&
		regWdata == 16'h0001 ##1 !(regWr && regAddr == ADDR_PULSE_LEN) [*1] |->
		pulseOn) else $error("pulse did not start");
	AST_RESTART: assert property (wrRestart |=> setup == SETUP_RESET)
		else $error("restart did not reset setup");

	COV_PULSE: cover property (pState == PS_RUN ##1 pState == PS_IDLE);
	COV_SELF: cover property (selfConvReq);
	COV_FULL: cover property (!fullFlag ##1 fullFlag);
endmodule : mcacsr_regs
`default_nettype wire

// ---- dv/mcacsr_flash_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ******************
// flash part model
// ******************
module mcacsr_flash_model #(
	parameter int          BUSY_CYC = 20,
	parameter logic [15:0] RD_WORD  = 16'h5a3c
) (
	input  wire logic        mclk,
	input  wire logic        wrStb,
	input  wire logic        rdStb,
	output logic             busy,
	output logic      [15:0] rdWord
);
	int left = 0;
	// every word access keeps the part busy for a while
	always @(posedge mclk) begin
		if (wrStb || rdStb) begin
			left <= BUSY_CYC;
		end else if (left > 0) begin
			left <= left - 1;
		end
	end
	assign busy = (left != 0);
	// word valid during a read strobe or while busy after any access; elsewhere the inverse, never a stale copy
	assign rdWord = (rdStb || busy) ? RD_WORD : ~RD_WORD;
endmodule // mcacsr_flash_model
`default_nettype wire

// ---- dv/tb_mca_control_status_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// **********
// testbench
// **********
module tb_mca_control_status_regs;
	import mcacsr_pkg::*;
	logic        mclk = 0;
	logic        rst_n = 0;
	logic        regWr = 0;
	logic        regRd = 0;
	logic [4:0]  regAddr = '0;
	logic [15:0] regWdata = '0;
	logic [15:0] regRdata;
	logic        bufferFilled = 0;
	logic        bufferEmpty = 1;
	logic        linkHighSpeed = 0;
	logic        peakDetect = 0;
	logic        nvmBusy;
	logic [15:0] nvmReadWord;
	logic        fpo, rampMode, dacTestMode, slideOn, selfGate, pileup_sense_on;
	logic        storeOn, countOn, selfConvReq, softRestart, nvm_access_permit;
	logic [15:0] nvm_word;
	logic        nvmWrStrobe, nvmRdStrobe;
	int          errors = 0;
	int          cmp_count = 0;
	int          nWr = 0, nRd = 0, nRst = 0, nConv = 0;
	always #10 mclk = ~mclk;
	mcacsr_regs i_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .nvmBusy(nvmBusy),
		.bufferFilled(bufferFilled), .bufferEmpty(bufferEmpty), .linkHighSpeed(linkHighSpeed),
		.peakDetect(peakDetect), .nvmReadWord(nvmReadWord), .front_panel_output(fpo),
		.rampMode(rampMode), .dacTestMode(dacTestMode), .slideOn(slideOn), .selfGate(selfGate),
		.pileup_sense_on(pileup_sense_on), .storeOn(storeOn), .countOn(countOn),
		.selfConvReq(selfConvReq), .softRestart(softRestart),
		.nvm_access_permit(nvm_access_permit), .nvm_word(nvm_word),
		.nvmWrStrobe(nvmWrStrobe), .nvmRdStrobe(nvmRdStrobe));
	mcacsr_flash_model i_flash (.mclk(mclk), .wrStb(nvmWrStrobe), .rdStb(nvmRdStrobe),
		.busy(nvmBusy), .rdWord(nvmReadWord));
	// pulse counters, sampled before the edge's updates land
	always @(posedge mclk) begin
		nWr <= nWr + (nvmWrStrobe === 1'b1);
		nRd <= nRd + (nvmRdStrobe === 1'b1);
		nRst <= nRst + (softRestart === 1'b1);
		nConv <= nConv + (selfConvReq === 1'b1);
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bus cycles; the trailing idle edge avoids two assignments in one step
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 d = regRdata;
		@(posedge mclk);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic finish_test;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// watchdog: the sequence needs well under 20k cycles, so 50k cycles is ample
	initial begin
		#1_000_000;
		errors++;
		finish_test;
	end
	// ***********
	// sequence
	// ***********
	initial begin
		logic [15:0] d;
		int          n, c;
		cyc(2);
		rst_n <= 1'b1;
		cyc(1);
		rdc(ADDR_SETUP, SETUP_RESET);
		rdc(ADDR_REVISION, {REV_MAJOR, REV_MINOR});
		rdc(ADDR_NVM_WORD, NVM_WORD_RESET);
		rdc(ADDR_NVM_GATE, 16'h0000);
		rdc(ADDR_PULSE_LEN, PULSE_LEN_RESET);
		rdc(5'h1f, 16'h0000);
		rdc(ADDR_CONDITION, 16'h0002);
		bufferEmpty <= 1'b0;
		linkHighSpeed <= 1'b1;
		cyc(2);
		rdc(ADDR_CONDITION, 16'h0001);
		// full flag sticks after the fill input drops
		bufferFilled <= 1'b1;
		cyc(1);
		bufferFilled <= 1'b0;
		cyc(2);
		rdc(ADDR_CONDITION, 16'h0005);
		#1 chk({15'h0, fpo}, 16'h0001);
		wr(ADDR_SETUP, 16'h002e);
		bufferFilled <= 1'b1;
		cyc(2);
		rdc(ADDR_CONDITION, 16'h0001);
		bufferFilled <= 1'b0;
		wr(ADDR_SETUP, 16'h000e);
		bufferFilled <= 1'b1;
		cyc(1);
		bufferFilled <= 1'b0;
		rdc(ADDR_CONDITION, 16'h0005);
		// restart drops the clear bit and the full flag
		c = nRst;
		wr(ADDR_SETUP, 16'h002e);
		wr(ADDR_RESTART, 16'h1234);
		cyc(1);
		chk(16'(nRst - c), 16'h0001);
		rd(ADDR_SETUP, d);
		chk(d & 16'h0020, 16'h0000);
		rdc(ADDR_CONDITION, 16'h0001);
		// restart alone, clear bit off, must drop a set full flag
		bufferFilled <= 1'b1;
		cyc(1);
		bufferFilled <= 1'b0;
		cyc(1);
		rdc(ADDR_CONDITION, 16'h0005);
		wr(ADDR_RESTART, 16'h0000);
		rdc(ADDR_CONDITION, 16'h0001);
		// configuration levels, reserved bit dropped
		wr(ADDR_SETUP, 16'hffff);
		rdc(ADDR_SETUP, 16'hfbff);
		chk({9'h0, rampMode, dacTestMode, slideOn, selfGate, pileup_sense_on,
			storeOn, countOn}, 16'h006f);
		wr(ADDR_SETUP, 16'h0050);
		#1 chk({9'h0, rampMode, dacTestMode, slideOn, selfGate, pileup_sense_on,
			storeOn, countOn}, 16'h0012);
		// front output sources
		peakDetect <= 1'b1;
		wr(ADDR_SETUP, 16'h2000);
		#1 chk({15'h0, fpo}, 16'h0001);
		peakDetect <= 1'b0;
		cyc(2);
		#1 chk({15'h0, fpo}, 16'h0000);
		wr(ADDR_SETUP, 16'hc000);
		#1 chk({15'h0, fpo}, 16'h0001);
		wr(ADDR_SETUP, 16'h4000);
		#1 chk({15'h0, fpo}, 16'h0000);
		wr(ADDR_SETUP, 16'h6000);
		wr(ADDR_PULSE_LEN, 16'h0002);
		n = 0;
		repeat (300) begin
			#1 n += (fpo === 1'b1);
			@(posedge mclk);
		end
		chk(16'(n), 16'(2 * PULSE_UNIT_CYC));
		rdc(ADDR_PULSE_LEN, 16'h0002);
		// self trigger spacing per rate code; code 0 is too slow to run here
		for (int k = 1; k < 8; k++) begin
			wr(ADDR_SETUP, 16'h0080 | 16'(k << 1));
			n = 0;
			while (selfConvReq !== 1'b1 && n < 2000) begin
				@(posedge mclk);
				#1 n++;
			end
			n = 0;
			do begin
				@(posedge mclk);
				#1 n++;
			end while (selfConvReq !== 1'b1 && n < 2000);
			chk(16'(n), 16'(CLK_HZ / RATE_SPS[k]));
		end
		wr(ADDR_SETUP, 16'h000e);
		cyc(2);
		c = nConv;
		cyc(300);
		chk(16'(nConv - c), 16'h0000);
		// flash port: refused while the gate is shut
		c = nWr;
		wr(ADDR_NVM_WORD, 16'h1234);
		cyc(1);
		chk(16'(nWr - c), 16'h0000);
		wr(ADDR_NVM_GATE, 16'hffff);
		rdc(ADDR_NVM_GATE, 16'h0001);
		chk({15'h0, nvm_access_permit}, 16'h0001);
		wr(ADDR_NVM_WORD, 16'h1234);
		cyc(1);
		chk(16'(nWr - c), 16'h0001);
		chk(nvm_word, 16'h1234);
		rdc(ADDR_CONDITION, 16'h0009);
		cyc(30);
		c = nRd;
		rd(ADDR_NVM_WORD, d);
		cyc(2);
		chk(16'(nRd - c), 16'h0001);
		chk(nvm_word, i_flash.RD_WORD);
		cyc(30);
		rdc(ADDR_CONDITION, 16'h0001);
		finish_test;
	end
endmodule // tb_mca_control_status_regs
`default_nettype wire
